/* rtl/gtc_pkg.sv */
// Package for the gated 16-bit timer/counter core
package gtc_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GATE = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_SLEEP = 8'h18;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_ON = 0;
    localparam int CTRL_SYNCDIS = 2;
    localparam int CTRL_OSCEN = 3;
    localparam int CTRL_PS_LO = 4;
    localparam int CTRL_CS_LO = 6;
    localparam int GATE_EN = 7;
    localparam int GATE_POL = 6;
    localparam int ST_OVF = 0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_FOSC = 16'h0004;
    localparam logic [1:0] IC_LAST = 2'b11;
    // Clock source encodings
    localparam logic [1:0] CS_INSTR = 2'b00;
    localparam logic [1:0] CS_FOSC = 2'b01;
    localparam logic [1:0] CS_EXT = 2'b10;
    localparam logic [1:0] CS_CAPS = 2'b11;

    typedef struct packed {
        logic [1:0] src_sel;
        logic [1:0] ps_sel;
        logic osc_en;
        logic sync_dis;
        logic on;
    } gtc_ctrl_t;

    typedef enum logic [1:0] {EDGE_ARMED, EDGE_WAIT_FALL} gtc_edge_t;
endpackage

/* rtl/gtc_core.sv */
// Gated 16-bit timer/counter core with an AXI4-Lite register slave
`timescale 1ns/1ps
// Operation
// R1 - 16-bit counter, byte writes replace live bytes
// R2 - Timer-on and gate-enable decide counting
// R3 - Two-bit select chooses the count source
// R4 - System clock source adds four per cycle
// R5 - Software gates asynchronously for full resolution
// R6 - External rising edges count, sync or async
// R7 - Falling edge required before first count
// R8 - Prescaler divides by 1, 2, 4, 8
// R9 - Prescaler hidden, cleared on count writes
// R10 - Oscillator enable starts crystal, survives sleep
// R11 - Software waits for oscillator before enabling
// R12 - Sync-disable bypasses the synchroniser
// R13 - Async external mode counts and wakes in sleep
// R14 - Mode switch may gain or lose one
// R15 - Rollover sets the overflow flag
// R16 - Gated mode counts while gate matches polarity
// R17 - Two-stage synchroniser before edge detection
module gtc_core import gtc_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_count_clock_pin,
    input wire logic cap_sense_osc_clock,
    input wire logic crystal_in_pin,
    input wire logic gate_input_pin,
    input wire logic sleep_mode,
    output logic crystal_out_pin,
    output logic crystal_out_oe,
    output logic irq,
    output logic wake_req
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    gtc_ctrl_t ctrl_q;
    logic gate_count_enable_q, gate_polarity_q;
    logic [15:0] count_q;
    logic [2:0] presc_q;
    logic [1:0] icyc_q;
    logic status_q, mask_q;
    gtc_edge_t edge_q;
    logic ext_s1_q, ext_s2_q, ext_prev_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // ----------------------------------------------------------------
    // Bus write path
    // ----------------------------------------------------------------
    logic wr_go, wr_lo, wr_hi, wr_st;
    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_lo = wr_go && awaddr_q == ADDR_CNT_LO && wstrb_q[0];
    assign wr_hi = wr_go && awaddr_q == ADDR_CNT_HI && wstrb_q[0];
    assign wr_st = wr_go && awaddr_q == ADDR_STATUS && wstrb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q <= ADDR_MASK) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0;
            gate_count_enable_q <= 1'b0;
            gate_polarity_q <= 1'b0;
            mask_q <= 1'b0;
        end else if (clk_en && wr_go && wstrb_q[0]) begin
            if (awaddr_q == ADDR_CTRL)
                ctrl_q <= gtc_ctrl_t'({wdata_q[CTRL_CS_LO+1:CTRL_SYNCDIS], wdata_q[CTRL_ON]});
            if (awaddr_q == ADDR_GATE) begin
                gate_count_enable_q <= wdata_q[GATE_EN];
                gate_polarity_q <= wdata_q[GATE_POL];
            end
            if (awaddr_q == ADDR_MASK)
                mask_q <= wdata_q[ST_OVF];
        end
    end

    // ----------------------------------------------------------------
    // Count source and enables
    // ----------------------------------------------------------------
    logic run, sel_ext_pin, ext_level, ext_async, ext_rise, ext_fall, src_tick;
    logic ext_raw;
    // Off regardless of gate bit when timer-on is clear
    assign run = ctrl_q.on && (!gate_count_enable_q ||
                 (gate_input_pin == gate_polarity_q)); // [R2] [R16]
    assign sel_ext_pin = ctrl_q.src_sel == CS_EXT;
    // Crystal replaces the pin when the oscillator is enabled
    assign ext_async = ctrl_q.osc_en ? crystal_in_pin : ext_count_clock_pin; // [R3] [R10]
    // Async mode skips the synchroniser stages, so at most one tick shifts on a switch
    assign ext_raw = sel_ext_pin ? ext_async : cap_sense_osc_clock; // [R6]
    assign ext_level = ctrl_q.sync_dis ? ext_raw : ext_s2_q; // [R12] [R14]
    assign ext_rise = ext_level && !ext_prev_q; // [R6]
    assign ext_fall = !ext_level && ext_prev_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else if (clk_en) begin
            ext_s1_q <= ext_raw; // [R17]
            ext_s2_q <= ext_s1_q; // [R17]
            ext_prev_q <= ext_level;
        end
    end

    // Rising edge after a falling one; rearm on disable or count write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_q <= EDGE_WAIT_FALL;
        end else if (clk_en) begin
            if (!ctrl_q.on || wr_lo || wr_hi)
                edge_q <= EDGE_WAIT_FALL; // [R7]
            else if (ext_fall)
                edge_q <= EDGE_ARMED; // [R7]
        end
    end

    always_comb begin
        case (ctrl_q.src_sel)
            CS_FOSC: src_tick = icyc_q == IC_LAST; // [R4]
            CS_INSTR: src_tick = icyc_q == IC_LAST; // [R3]
            CS_EXT, CS_CAPS: src_tick = ext_rise && edge_q == EDGE_ARMED; // [R6] [R7]
            default: src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            icyc_q <= '0;
        else if (clk_en)
            icyc_q <= icyc_q + 2'b01;
    end

    // ----------------------------------------------------------------
    // Prescaler and counter
    // ----------------------------------------------------------------
    logic presc_tick, cnt_tick;
    logic [15:0] step;
    logic [16:0] sum;
    // Sleep freezes counting for all sources but the async external and cap-sense paths
    logic awake_ok;
    assign awake_ok = !sleep_mode || (ctrl_q.sync_dis && ctrl_q.src_sel[1]); // [R13]
    assign presc_tick = run && awake_ok && src_tick;
    always_comb begin
        case (ctrl_q.ps_sel)
            2'b00: cnt_tick = presc_tick;
            2'b01: cnt_tick = presc_tick && presc_q[0] == 1'b1;
            2'b10: cnt_tick = presc_tick && presc_q[1:0] == 2'b11;
            default: cnt_tick = presc_tick && presc_q == 3'b111;
        endcase
    end
    // Four counts per cycle leave the low two bits meaningless
    assign step = (ctrl_q.src_sel == CS_FOSC) ? STEP_FOSC : STEP_ONE; // [R4]
    assign sum = {1'b0, count_q} + {1'b0, step};

    always_ff @(posedge aclk) begin
        if (!aresetn)
            presc_q <= '0;
        else if (clk_en) begin
            if (wr_lo || wr_hi)
                presc_q <= '0; // [R9]
            else if (presc_tick)
                presc_q <= presc_q + 3'b001; // [R8]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            count_q <= '0;
        else if (clk_en) begin
            if (wr_lo)
                count_q[7:0] <= wdata_q[7:0]; // [R1]
            else if (wr_hi)
                count_q[15:8] <= wdata_q[7:0]; // [R1]
            else if (cnt_tick)
                count_q <= sum[15:0]; // [R1]
        end
    end

    // ----------------------------------------------------------------
    // Overflow flag, interrupt, crystal drive
    // ----------------------------------------------------------------
    logic ovf_ev;
    assign ovf_ev = cnt_tick && !wr_lo && !wr_hi && sum[16];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= 1'b0;
            irq <= 1'b0;
            wake_req <= 1'b0;
            crystal_out_pin <= 1'b0;
            crystal_out_oe <= 1'b0;
        end else if (clk_en) begin
            // Set wins over a same-cycle write-one clear
            if (ovf_ev)
                status_q <= 1'b1; // [R15]
            else if (wr_st && wdata_q[ST_OVF])
                status_q <= 1'b0;
            irq <= (status_q || ovf_ev) && mask_q;
            wake_req <= sleep_mode && ovf_ev && mask_q; // [R13]
            crystal_out_oe <= ctrl_q.osc_en; // [R10]
            crystal_out_pin <= !crystal_in_pin;
        end
    end

    // ----------------------------------------------------------------
    // Bus read path
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr)
                    ADDR_CTRL: s_axi_rdata <= {24'h000000, ctrl_q[6:1], 1'b0, ctrl_q.on};
                    ADDR_GATE: s_axi_rdata <= {24'h000000, gate_count_enable_q,
                                               gate_polarity_q, 6'h00};
                    ADDR_CNT_LO: s_axi_rdata <= {24'h000000, count_q[7:0]};
                    ADDR_CNT_HI: s_axi_rdata <= {24'h000000, count_q[15:8]};
                    ADDR_STATUS: s_axi_rdata <= {31'h00000000, status_q};
                    ADDR_MASK: s_axi_rdata <= {31'h00000000, mask_q};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    off_holds_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        clk_en && !ctrl_q.on && !wr_lo && !wr_hi |=> $stable(count_q))
        else $error("count moved while off");
    fosc_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        clk_en && cnt_tick && !wr_lo && !wr_hi && ctrl_q.src_sel == CS_FOSC
        |=> count_q[1:0] == $past(count_q[1:0]))
        else $error("fosc step not four");
    write_lo_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
        clk_en && wr_lo |=> count_q[7:0] == $past(wdata_q[7:0]))
        else $error("low byte write lost");
    presc_clr_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
        clk_en && (wr_lo || wr_hi) |=> presc_q == 3'b000)
        else $error("prescaler not cleared");
    ovf_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
        clk_en && ovf_ev |=> status_q ##1 1'b1)
        else $error("overflow flag not set");
    rearm_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        clk_en && (wr_hi || !ctrl_q.on) |=> edge_q == EDGE_WAIT_FALL)
        else $error("edge guard not rearmed");
    gate_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
        gate_count_enable_q && gate_input_pin != gate_polarity_q |-> !cnt_tick)
        else $error("counted with gate closed");
    div8_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
        cnt_tick && ctrl_q.ps_sel == 2'b11 |-> presc_q == 3'b111)
        else $error("divide by eight broken");
    irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
        clk_en && status_q && mask_q ##1 clk_en |-> irq)
        else $error("irq not raised");
endmodule // gtc_core

/* bench/gtc_far_model.sv */
// Far-side model: external count clock, cap-sense oscillator and crystal
`timescale 1ns/1ps
module gtc_far_model (
    input wire logic aclk,
    input wire logic crystal_out_oe,
    output logic ext_count_clock_pin,
    output logic cap_sense_osc_clock,
    output logic crystal_in_pin
);
    logic [2:0] xdiv_q = 3'h0;
    initial begin
        ext_count_clock_pin = 1'b0;
        cap_sense_osc_clock = 1'b0;
        crystal_in_pin = 1'b0;
    end
    // Crystal swings only while its driver is enabled, far slower than aclk
    always @(posedge aclk) begin
        xdiv_q <= crystal_out_oe ? xdiv_q + 3'h1 : 3'h0;
        if (!crystal_out_oe) crystal_in_pin <= 1'b0;
        else if (xdiv_q == 3'h7) crystal_in_pin <= ~crystal_in_pin;
    end
    // Four cycles high, four low: wide enough for the synchroniser
    task automatic pulse(input bit cap, input int n);
        repeat (n) begin
            @(posedge aclk);
            if (cap) cap_sense_osc_clock <= 1'b1;
            else ext_count_clock_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            cap_sense_osc_clock <= 1'b0;
            ext_count_clock_pin <= 1'b0;
            repeat (3) @(posedge aclk);
        end
    endtask
endmodule // gtc_far_model

/* bench/tb_top.sv */
// Self-checking testbench for the timer/counter core
`timescale 1ns/1ps
module tb_top import gtc_pkg::*;;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic gate = 1'b0, sleep = 1'b0, wake_seen = 1'b0;
    logic xin_d = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake, xo, xoe, ext, cap, xin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, v;
    logic [15:0] cnt;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    gtc_core dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_count_clock_pin(ext),
        .cap_sense_osc_clock(cap), .crystal_in_pin(xin), .gate_input_pin(gate),
        .sleep_mode(sleep), .crystal_out_pin(xo), .crystal_out_oe(xoe), .irq(irq),
        .wake_req(wake));
    gtc_far_model far (.aclk(aclk), .crystal_out_oe(xoe), .ext_count_clock_pin(ext),
        .cap_sense_osc_clock(cap), .crystal_in_pin(xin));

    initial forever #50 aclk = ~aclk;
    // Wake is a one-cycle pulse, so latch it for a later look
    always @(posedge aclk) begin
        if (wake === 1'b1) wake_seen <= 1'b1;
        xin_d <= xin;
    end
    // Generous ceiling: the whole sequence needs well under 10000 cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            finish_test;
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rng(input logic [31:0] got, input int lo, input int hi);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        samples_checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        rready <= 1'b0;
    endtask
    task automatic rd_cnt;
        axi_rd(ADDR_CNT_LO, v);
        cnt[7:0] = v[7:0];
        axi_rd(ADDR_CNT_HI, v);
        cnt[15:8] = v[7:0];
    endtask
    function automatic logic [31:0] ctl(logic [1:0] s, logic [1:0] p, logic o, logic d);
        return {24'h0, s, p, o, d, 2'b01};
    endfunction
    // Clear the count, run for n cycles or n pulses, stop, read back
    task automatic run(input logic [31:0] c, input int n, input int pin);
        axi_wr(ADDR_CNT_LO, 32'h0);
        axi_wr(ADDR_CNT_HI, 32'h0);
        axi_wr(ADDR_CTRL, c);
        if (pin < 0) repeat (n) @(posedge aclk);
        else far.pulse(pin == 1, n);
        axi_wr(ADDR_CTRL, c & 32'hffff_fffe);
        rd_cnt;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ADDR_CTRL, v);
        chk(v, 32'h0);
        axi_rd(ADDR_SLEEP, v);
        chk({30'h0, rresp}, {30'h0, RESP_SLVERR});
        axi_wr(ADDR_CNT_LO, 32'h34);
        axi_wr(ADDR_CNT_HI, 32'h12);
        repeat (40) @(posedge aclk);
        rd_cnt;
        chk({16'h0, cnt}, 32'h1234);
        for (int p = 0; p < 4; p++) begin
            run(ctl(CS_INSTR, p[1:0], 1'b0, 1'b0), 480, -1);
            rng({16'h0, cnt}, (120 >> p) - 2, (120 >> p) + 2);
        end
        run(ctl(CS_FOSC, 2'b00, 1'b0, 1'b0), 100, -1);
        chk({30'h0, cnt[1:0]}, 32'h0);
        rng({16'h0, cnt}, 96, 112);
        // First rise after the count write is swallowed, so five pulses give four
        for (int i = 0; i < 3; i++) begin
            run(ctl(i == 2 ? CS_CAPS : CS_EXT, 2'b00, 1'b0, i == 1), 5, i == 2);
            chk({16'h0, cnt}, 32'h4);
        end
        axi_wr(ADDR_GATE, 32'hc0);
        run(ctl(CS_INSTR, 2'b00, 1'b0, 1'b0), 200, -1);
        chk({16'h0, cnt}, 32'h0);
        run(ctl(CS_FOSC, 2'b00, 1'b0, 1'b0), 100, -1);
        chk({16'h0, cnt}, 32'h0);
        gate <= 1'b1;
        run(ctl(CS_INSTR, 2'b00, 1'b0, 1'b0), 200, -1);
        rng({16'h0, cnt}, 45, 56);
        axi_wr(ADDR_GATE, 32'h0);
        axi_wr(ADDR_MASK, 32'h1);
        axi_wr(ADDR_CNT_LO, 32'hff);
        axi_wr(ADDR_CNT_HI, 32'hff);
        sleep <= 1'b1;
        axi_wr(ADDR_CTRL, ctl(CS_EXT, 2'b00, 1'b0, 1'b1));
        far.pulse(1'b0, 2);
        rd_cnt;
        chk({16'h0, cnt}, 32'h0);
        axi_rd(ADDR_STATUS, v);
        chk(v, 32'h1);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, wake_seen}, 32'h1);
        sleep <= 1'b0;
        axi_wr(ADDR_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        axi_wr(ADDR_STATUS, 32'h1);
        axi_rd(ADDR_STATUS, v);
        chk(v, 32'h0);
        axi_wr(ADDR_CTRL, ctl(CS_EXT, 2'b00, 1'b1, 1'b1) & 32'hffff_fffe);
        repeat (100) @(posedge aclk);
        chk({31'h0, xoe}, 32'h1);
        chk({31'h0, xo}, {31'h0, ~xin_d});
        run(ctl(CS_EXT, 2'b00, 1'b1, 1'b1), 200, -1);
        rng({16'h0, cnt}, 1, 40);
        finish_test;
    end
endmodule // tb_top
